/* core/ich_pkg.sv */
// Shared constants and types of the controller command handler
package ich_pkg;

  // ----------------------------------------------------------------
  // Byte layout
  // ----------------------------------------------------------------
  localparam int          BYTE_W      = 8;
  localparam int          REQ_INT_BIT = 7;
  localparam int          CODE_W      = 5;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          PB_BYTES    = 5;
  localparam logic [2:0]  PB_LAST_IDX = 3'h4;
  localparam logic [2:0]  PB_FIRST_IDX = 3'h0;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CMD_DEV_STATUS    = 5'h03;
  localparam logic [CODE_W-1:0] CMD_INT_RESET     = 5'h04;
  localparam logic [CODE_W-1:0] CMD_INT_CLEAR     = 5'h05;
  localparam logic [CODE_W-1:0] CMD_INT_ENABLE    = 5'h0a;
  localparam logic [CODE_W-1:0] CMD_DISP_CHAR     = 5'h10;
  localparam logic [CODE_W-1:0] CMD_DISP_STATUS   = 5'h11;
  localparam logic [CODE_W-1:0] CMD_KEY_CHAR      = 5'h12;
  localparam logic [CODE_W-1:0] CMD_KEY_STATUS    = 5'h13;
  localparam logic [CODE_W-1:0] CMD_PARAM_FIRST   = 5'h15;
  localparam logic [CODE_W-1:0] CMD_PARAM_NEXT    = 5'h16;
  localparam logic [CODE_W-1:0] CMD_DISK_WRITE    = 5'h17;

  // ----------------------------------------------------------------
  // Device status byte: interrupt bit = device, error bit = offset + device
  // ----------------------------------------------------------------
  localparam int DEV_DISP    = 0;
  localparam int DEV_KBD     = 1;
  localparam int DEV_DISK    = 2;
  localparam int DEV_N       = 3;
  localparam int DEV_ERR_OFS = 4;

  // Display status byte
  localparam int DST_ILL_DATA = 0;
  localparam int DST_ILL_STAT = 1;

  // Keyboard status byte
  localparam int KST_DATA_READY   = 0;
  localparam int KST_DISP_PRESENT = 1;
  localparam int KST_KBD_PRESENT  = 2;
  localparam int KST_ILL_REQ      = 3;
  localparam int KST_TIMEOUT      = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             is_cmd;
    logic [BYTE_W-1:0] data;
  } ich_hb_word_t;

  typedef struct packed {
    logic [BYTE_W-1:0] channel;
    logic [BYTE_W-1:0] instr;
    logic [BYTE_W-1:0] count;
    logic [BYTE_W-1:0] track;
    logic [BYTE_W-1:0] sector;
  } ich_param_block_t;

  typedef enum logic [2:0] {
    PEND_NONE     = 3'b000,
    PEND_DISP     = 3'b001,
    PEND_PB_FIRST = 3'b010,
    PEND_PB_NEXT  = 3'b011,
    PEND_INT_EN   = 3'b100,
    PEND_INT_RST  = 3'b101
  } ich_pend_t;

  typedef enum logic [1:0] {
    OUT_OTHER     = 2'b00,
    OUT_DISP_STAT = 2'b01,
    OUT_KBD_STAT  = 2'b10,
    OUT_DEV_STAT  = 2'b11
  } ich_out_kind_t;

endpackage

/* core/ich_fifo.sv */
// Input byte FIFO between the host data buffer and the command handler
`timescale 1ns/100ps
`default_nettype none
module ich_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output var  logic             o_ready,
  output var  logic             o_valid,
  output var  logic [WIDTH-1:0] o_data,
  input  wire logic             i_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("ich_fifo depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push   = i_valid & o_ready;
  assign pop    = o_valid & i_ready;
  assign o_data = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q   <= cnt_d;
      o_ready <= (cnt_d != FULL_CNT);
      o_valid <= (cnt_d != '0);
    end
  end

endmodule // ich_fifo
`default_nettype wire

/* core/ich_top.sv */
// Command handler of the I/O controller facing the master processor
//
// Functional notes
// - Byte after display char command goes to display
// - Request bit or enable sets display interrupt
// - Display status command returns byte, clears error
// - Stray data byte sets display illegal-data flag
// - Display status command with request bit flags illegal
// - Keyboard char fetches byte, ignores request bit
// - Keyboard status command returns keyboard status byte
// - Display-present set once initialisation is done
// - Data-ready follows keyboard byte availability
// - Keyboard-present follows keyboard connection
// - Keyboard status with request bit flags illegal
// - Keyboard char without data sets timeout
// - Parameter block holds five bytes
// - Last parameter byte starts diskette transfer
// - First parameter command stores channel word
// - Next parameter command stores next byte
// - Display command codes 10000 and 10001
// - Keyboard command codes 10010 and 10011
// - Parameter codes 10101, 10110; write data 10111
`timescale 1ns/100ps
`default_nettype none
module ich_top #(
  parameter int FIFO_DEPTH = ich_pkg::FIFO_DEPTH
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  input  wire logic                      i_hb_wr,
  input  wire ich_pkg::ich_hb_word_t     i_hb_word,
  output var  logic                      o_hb_ready,
  input  wire logic                      i_ob_read,
  output var  logic                      o_obf,
  output var  logic [7:0]                o_ob_data,
  input  wire logic                      i_int_mask,
  output var  logic                      o_int,
  input  wire logic                      i_kbd_valid,
  input  wire logic [7:0]                i_kbd_char,
  input  wire logic                      i_kbd_present,
  output var  logic                      o_kbd_take,
  output var  logic                      o_disp_wr,
  output var  logic [7:0]                o_disp_char,
  output var  logic                      o_disk_start,
  output var  ich_pkg::ich_param_block_t o_param_block
);
  import ich_pkg::*;

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("ich_top needs an input FIFO of at least two words");
    end
  end

  // ----------------------------------------------------------------
  // Input FIFO
  // ----------------------------------------------------------------
  ich_hb_word_t f_word;
  logic         f_valid;
  logic         ob_free;

  assign ob_free = ~o_obf;

  ich_fifo #(
    .WIDTH ($bits(ich_hb_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_valid (i_hb_wr),
    .i_data  (i_hb_word),
    .o_ready (o_hb_ready),
    .o_valid (f_valid),
    .o_data  (f_word),
    .i_ready (ob_free)
  );

  // ----------------------------------------------------------------
  // Decode of the byte taken this cycle
  // ----------------------------------------------------------------
  function automatic logic is_cmd_code(input ich_hb_word_t w, input logic [CODE_W-1:0] c);
    return w.is_cmd && (w.data[CODE_W-1:0] == c);
  endfunction

  logic pop;
  logic req_bit;
  logic take_data;

  assign pop       = f_valid & ob_free;
  assign req_bit   = f_word.data[REQ_INT_BIT];
  assign take_data = pop & ~f_word.is_cmd;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ich_pend_t         pend_q;
  logic              pend_req_q;
  ich_out_kind_t     out_kind_q;
  logic [2:0]        pb_idx_q;
  logic [DEV_N-1:0]  dev_int_q;
  logic [DEV_N-1:0]  dev_err_q;
  logic [DEV_N-1:0]  int_en_q;
  logic              disp_ill_data_q;
  logic              disp_ill_stat_q;
  logic              kbd_ill_req_q;
  logic              kbd_timeout_q;
  logic              disp_present_q;
  logic              kbd_valid_q;
  logic [7:0]        disp_stat_byte;
  logic [7:0]        kbd_stat_byte;
  logic [7:0]        dev_stat_byte;
  logic              ob_clear;
  logic              disp_store;
  logic              pb_store;

  assign ob_clear   = i_ob_read & o_obf;
  assign disp_store = take_data & (pend_q == PEND_DISP);
  assign pb_store   = take_data & ((pend_q == PEND_PB_FIRST) | (pend_q == PEND_PB_NEXT));

  always_comb begin
    disp_stat_byte               = BYTE_ZERO;
    disp_stat_byte[DST_ILL_DATA] = disp_ill_data_q;
    disp_stat_byte[DST_ILL_STAT] = disp_ill_stat_q;
    kbd_stat_byte                   = BYTE_ZERO;
    kbd_stat_byte[KST_DATA_READY]   = i_kbd_valid;
    kbd_stat_byte[KST_DISP_PRESENT] = disp_present_q;
    kbd_stat_byte[KST_KBD_PRESENT]  = i_kbd_present;
    kbd_stat_byte[KST_ILL_REQ]      = kbd_ill_req_q;
    kbd_stat_byte[KST_TIMEOUT]      = kbd_timeout_q;
    dev_stat_byte                                 = BYTE_ZERO;
    dev_stat_byte[DEV_N-1:0]                      = dev_int_q;
    dev_stat_byte[DEV_ERR_OFS+DEV_N-1:DEV_ERR_OFS] = dev_err_q;
  end

  // ----------------------------------------------------------------
  // Data byte expectation
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_q     <= PEND_NONE;
      pend_req_q <= 1'b0;
    end else if (pop) begin
      pend_req_q <= f_word.is_cmd ? req_bit : 1'b0;
      if (f_word.is_cmd) begin
        case (f_word.data[CODE_W-1:0])
          CMD_DISP_CHAR:   pend_q <= PEND_DISP;
          CMD_PARAM_FIRST: pend_q <= PEND_PB_FIRST;
          CMD_PARAM_NEXT:  pend_q <= PEND_PB_NEXT;
          CMD_INT_ENABLE:  pend_q <= PEND_INT_EN;
          CMD_INT_RESET:   pend_q <= PEND_INT_RST;
          default:         pend_q <= PEND_NONE;
        endcase
      end else begin
        pend_q <= PEND_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Display path
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_disp_wr   <= 1'b0;
      o_disp_char <= BYTE_ZERO;
    end else begin
      o_disp_wr <= disp_store;
      if (disp_store) begin
        o_disp_char <= f_word.data;
      end
    end
  end

  // Sticky display flags: a set in the read cycle wins over the clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      disp_ill_data_q <= 1'b0;
      disp_ill_stat_q <= 1'b0;
    end else begin
      if (ob_clear && out_kind_q == OUT_DISP_STAT) begin
        disp_ill_data_q <= 1'b0;
        disp_ill_stat_q <= 1'b0;
      end
      if (take_data && pend_q == PEND_NONE) begin
        disp_ill_data_q <= 1'b1;
      end
      if (pop && is_cmd_code(f_word, CMD_DISP_STATUS) && req_bit) begin
        disp_ill_stat_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Keyboard flags and presence
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      kbd_ill_req_q  <= 1'b0;
      kbd_timeout_q  <= 1'b0;
      disp_present_q <= 1'b0;
      kbd_valid_q    <= 1'b0;
    end else begin
      disp_present_q <= 1'b1;
      kbd_valid_q    <= i_kbd_valid;
      if (ob_clear && out_kind_q == OUT_KBD_STAT) begin
        kbd_ill_req_q <= 1'b0;
        kbd_timeout_q <= 1'b0;
      end
      if (pop && is_cmd_code(f_word, CMD_KEY_STATUS) && req_bit) begin
        kbd_ill_req_q <= 1'b1;
      end
      if (pop && is_cmd_code(f_word, CMD_KEY_CHAR) && !i_kbd_valid) begin
        kbd_timeout_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output data buffer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_obf      <= 1'b0;
      o_ob_data  <= BYTE_ZERO;
      out_kind_q <= OUT_OTHER;
      o_kbd_take <= 1'b0;
    end else begin
      o_kbd_take <= 1'b0;
      if (ob_clear) begin
        o_obf <= 1'b0;
      end
      if (pop && f_word.is_cmd) begin
        case (f_word.data[CODE_W-1:0])
          CMD_DISP_STATUS: begin
            o_obf      <= 1'b1;
            o_ob_data  <= disp_stat_byte;
            o_ob_data[DST_ILL_STAT] <= disp_ill_stat_q | req_bit;
            out_kind_q <= OUT_DISP_STAT;
          end
          CMD_KEY_STATUS: begin
            o_obf      <= 1'b1;
            o_ob_data  <= kbd_stat_byte;
            o_ob_data[KST_ILL_REQ] <= kbd_ill_req_q | req_bit;
            out_kind_q <= OUT_KBD_STAT;
          end
          CMD_KEY_CHAR: begin
            o_obf      <= 1'b1;
            o_ob_data  <= i_kbd_valid ? i_kbd_char : BYTE_ZERO;
            o_kbd_take <= i_kbd_valid;
            out_kind_q <= OUT_OTHER;
          end
          CMD_DEV_STATUS: begin
            o_obf      <= 1'b1;
            o_ob_data  <= dev_stat_byte;
            out_kind_q <= OUT_DEV_STAT;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Device interrupts, enables and errors
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_en_q <= '0;
    end else if (take_data && pend_q == PEND_INT_EN) begin
      int_en_q <= f_word.data[DEV_N-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dev_int_q <= '0;
    end else begin
      if (pop && is_cmd_code(f_word, CMD_INT_CLEAR)) begin
        dev_int_q <= '0;
      end else if (take_data && pend_q == PEND_INT_RST) begin
        dev_int_q <= dev_int_q & ~f_word.data[DEV_N-1:0];
      end
      if (disp_store && (pend_req_q || int_en_q[DEV_DISP])) begin
        dev_int_q[DEV_DISP] <= 1'b1;
      end
      if (i_kbd_valid && !kbd_valid_q && int_en_q[DEV_KBD]) begin
        dev_int_q[DEV_KBD] <= 1'b1;
      end
      if (pb_store && (pend_req_q || int_en_q[DEV_DISK])) begin
        dev_int_q[DEV_DISK] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dev_err_q <= '0;
    end else begin
      if (ob_clear && out_kind_q == OUT_DEV_STAT) begin
        dev_err_q <= '0;
      end
      if (pop && is_cmd_code(f_word, CMD_DISP_STATUS)) begin
        dev_err_q[DEV_DISP] <= 1'b0;
      end
      if ((take_data && pend_q == PEND_NONE) || (pop && is_cmd_code(f_word, CMD_DISP_STATUS) && req_bit)) begin
        dev_err_q[DEV_DISP] <= 1'b1;
      end
      if (pop && f_word.is_cmd && req_bit && f_word.data[CODE_W-1:0] == CMD_KEY_STATUS) begin
        dev_err_q[DEV_KBD] <= 1'b1;
      end
      if (pop && is_cmd_code(f_word, CMD_KEY_CHAR) && !i_kbd_valid) begin
        dev_err_q[DEV_KBD] <= 1'b1;
      end
      if (pb_store && pend_q == PEND_PB_NEXT && pb_idx_q == PB_LAST_IDX) begin
        dev_err_q[DEV_DISK] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_int <= 1'b0;
    end else begin
      o_int <= (|dev_int_q) & ~i_int_mask;
    end
  end

  // ----------------------------------------------------------------
  // Parameter block store and diskette start
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pb_idx_q      <= PB_LAST_IDX;
      o_param_block <= '0;
      o_disk_start  <= 1'b0;
    end else begin
      o_disk_start <= 1'b0;
      if (pb_store && pend_q == PEND_PB_FIRST) begin
        o_param_block.channel <= f_word.data;
        pb_idx_q              <= PB_FIRST_IDX;
      end else if (pb_store && pb_idx_q != PB_LAST_IDX) begin
        case (pb_idx_q)
          3'h0:    o_param_block.instr  <= f_word.data;
          3'h1:    o_param_block.count  <= f_word.data;
          3'h2:    o_param_block.track  <= f_word.data;
          default: o_param_block.sector <= f_word.data;
        endcase
        pb_idx_q     <= pb_idx_q + 3'h1;
        o_disk_start <= (pb_idx_q + 3'h1 == PB_LAST_IDX);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_disp_char_store: assert property (disp_store |=> o_disp_wr && o_disp_char == $past(f_word.data))
    else $error("display byte not written");
  a_disp_int_set: assert property (disp_store && (pend_req_q || int_en_q[DEV_DISP]) |=> ##1 dev_stat_byte[DEV_DISP] && (o_int || $past(i_int_mask)))
    else $error("display interrupt missing");
  a_disp_stat_out: assert property (pop && is_cmd_code(f_word, CMD_DISP_STATUS) |=> o_obf && out_kind_q == OUT_DISP_STAT && !dev_err_q[DEV_DISP] == !$past(req_bit))
    else $error("display status not returned");
  a_ill_data_flag: assert property (take_data && pend_q == PEND_NONE |=> o_disp_wr == 1'b0 && disp_stat_byte[DST_ILL_DATA])
    else $error("illegal data flag not set");
  a_ill_stat_flag: assert property (pop && is_cmd_code(f_word, CMD_DISP_STATUS) && req_bit |=> o_ob_data[DST_ILL_STAT] && disp_ill_stat_q)
    else $error("illegal status flag not set");
  a_kbd_char_take: assert property (pop && is_cmd_code(f_word, CMD_KEY_CHAR) && i_kbd_valid |=> o_kbd_take && o_ob_data == $past(i_kbd_char))
    else $error("keyboard byte not fetched");
  a_kbd_stat_out: assert property (pop && is_cmd_code(f_word, CMD_KEY_STATUS) |=> o_obf && o_ob_data[KST_KBD_PRESENT] == $past(i_kbd_present))
    else $error("keyboard status not returned");
  a_disp_present: assert property ($rose(i_rst_b) |-> ##2 disp_present_q)
    else $error("display present not set");
  a_kbd_timeout: assert property (pop && is_cmd_code(f_word, CMD_KEY_CHAR) && !i_kbd_valid |=> kbd_timeout_q && !o_kbd_take)
    else $error("keyboard timeout not flagged");
  a_kbd_flag_clear: assert property (ob_clear && out_kind_q == OUT_KBD_STAT && !pop |=> !kbd_timeout_q && !kbd_ill_req_q)
    else $error("keyboard flags not cleared on read");
  a_disk_start_last: assert property (pb_store && pend_q == PEND_PB_NEXT && pb_idx_q == 3'h3 |=> o_disk_start && o_param_block.sector == $past(f_word.data))
    else $error("diskette start missing after last byte");
  a_disk_start_only: assert property (o_disk_start |-> $past(pb_store) && pb_idx_q == PB_LAST_IDX)
    else $error("diskette start without full block");

endmodule // ich_top
`default_nettype wire

/* verif/ich_kbd_model.sv */
// Keyboard processor model facing the command handler
`timescale 1ns/100ps
`default_nettype none
module ich_kbd_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_press,
  input  wire logic [7:0] i_key,
  input  wire logic       i_take,
  input  wire logic       i_plug,
  output var  logic       o_valid,
  output var  logic [7:0] o_char,
  output var  logic       o_present
);
  assign o_present = i_plug;
  // Char lines toggle while no byte is valid, so a stale byte never matches
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_valid <= 1'b0;
      o_char  <= 8'h00;
    end else if (i_press) begin
      o_valid <= 1'b1;
      o_char  <= i_key;
    end else if (i_take) begin
      o_valid <= 1'b0;
    end else if (!o_valid) begin
      o_char <= ~o_char;
    end
  end
endmodule // ich_kbd_model
`default_nettype wire

/* verif/tb_ich_top.sv */
// Self-checking bench of the command handler
`timescale 1ns/100ps
`default_nettype none
module tb_ich_top;
  import ich_pkg::*;
  localparam logic [2:0] RQ = 3'h4;
  localparam logic [2:0] NR = 3'h0;
  logic             i_clk = 1'b0;
  logic             i_rst_b = 1'b0;
  logic             i_hb_wr = 1'b0;
  logic             i_ob_read = 1'b0;
  logic             i_int_mask = 1'b0;
  logic             press = 1'b0;
  logic             hold = 1'b0;
  logic             plug = 1'b1;
  logic       [7:0] key = 8'h00;
  logic       [7:0] c;
  ich_hb_word_t     i_hb_word = '0;
  logic             o_hb_ready, o_obf, o_int, o_kbd_take, o_disp_wr, o_disk_start;
  logic             kbd_valid, kbd_present;
  logic       [7:0] o_ob_data, o_disp_char, kbd_char;
  ich_param_block_t o_param_block, pb;
  logic      [15:0] q_ob[$];
  logic       [7:0] q_ch[$];
  ich_param_block_t q_pb[$];
  int               n_mismatch = 0;
  int               n_checks = 0;

  always #5 i_clk = ~i_clk;

  ich_top dut (.i_clk, .i_rst_b, .i_hb_wr, .i_hb_word, .o_hb_ready, .i_ob_read, .o_obf,
    .o_ob_data, .i_int_mask, .o_int, .i_kbd_valid(kbd_valid), .i_kbd_char(kbd_char),
    .i_kbd_present(kbd_present), .o_kbd_take, .o_disp_wr, .o_disp_char, .o_disk_start,
    .o_param_block);
  ich_kbd_model kbd (.i_clk, .i_rst_b, .i_press(press), .i_key(key), .i_take(o_kbd_take), .i_plug(plug),
    .o_valid(kbd_valid), .o_char(kbd_char), .o_present(kbd_present));

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    n_checks++;
    if ((got & msk) !== (exp & msk)) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pb(input ich_param_block_t got, input ich_param_block_t exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Holds the word until an edge that sees the buffer ready
  task automatic push(input logic cm, input logic [7:0] d);
    i_hb_wr   <= 1'b1;
    i_hb_word <= '{is_cmd: cm, data: d};
    @(negedge i_clk);
    for (int t = 0; t < 300 && o_hb_ready !== 1'b1; t++) @(negedge i_clk);
    if (o_hb_ready !== 1'b1) n_mismatch++;
    @(posedge i_clk);
  endtask

  task automatic ob(input logic [7:0] cd, input logic [7:0] v, input logic [7:0] m = 8'hff);
    q_ob.push_back({m, v});
    push(1'b1, cd);
  endtask

  task automatic drain;
    i_hb_wr <= 1'b0;
    for (int t = 0; t < 300 && (q_ob.size() + q_ch.size() + q_pb.size()) > 0; t++) @(posedge i_clk);
    if ((q_ob.size() + q_ch.size() + q_pb.size()) > 0) n_mismatch++;
    repeat (4) @(posedge i_clk);
  endtask

  // Result watcher; it also empties the output buffer unless held
  always @(posedge i_clk) begin
    if (o_disp_wr === 1'b1) cmp8(o_disp_char, q_ch.pop_front(), 8'hff);
    if (o_disk_start === 1'b1) cmp_pb(o_param_block, q_pb.pop_front());
    if (i_ob_read) begin
      i_ob_read <= 1'b0;
    end else if (o_obf === 1'b1 && !hold) begin
      cmp8(o_ob_data, q_ob[0][7:0], q_ob[0][15:8]);
      void'(q_ob.pop_front());
      i_ob_read <= 1'b1;
    end
  end

  initial begin
    #200000;
    n_mismatch++;
    final_report;
  end

  initial begin
    void'($urandom(87965));
    c = 8'($urandom);
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_clk);
    push(1'b0, c);
    ob({NR, CMD_DISP_STATUS}, 8'h01);
    ob({NR, CMD_DEV_STATUS}, 8'h00);
    ob({RQ, CMD_DISP_STATUS}, 8'h02);
    ob({NR, CMD_DEV_STATUS}, 8'h10);
    ob({NR, CMD_DISP_STATUS}, 8'h00);
    q_ch.push_back(c);
    push(1'b1, {RQ, CMD_DISP_CHAR});
    push(1'b0, c);
    drain;
    cmp8({7'h0, o_int}, 8'h01, 8'hff);
    ob({NR, CMD_DEV_STATUS}, 8'h01);
    i_int_mask <= 1'b1;
    drain;
    cmp8({7'h0, o_int}, 8'h00, 8'hff);
    i_int_mask <= 1'b0;
    push(1'b1, {NR, CMD_INT_CLEAR});
    c = 8'($urandom);
    q_ch.push_back(c);
    push(1'b1, {NR, CMD_DISP_CHAR});
    push(1'b0, c);
    ob({NR, CMD_DEV_STATUS}, 8'h00);
    drain;
    cmp8({7'h0, o_int}, 8'h00, 8'hff);
    ob({NR, CMD_KEY_STATUS}, 8'h06);
    ob({NR, CMD_KEY_CHAR}, 8'h00);
    ob({NR, CMD_KEY_STATUS}, 8'h16);
    ob({RQ, CMD_KEY_STATUS}, 8'h0e);
    ob({NR, CMD_KEY_STATUS}, 8'h06);
    drain;
    c = 8'($urandom);
    key   <= c;
    press <= 1'b1;
    @(posedge i_clk);
    press <= 1'b0;
    ob({NR, CMD_KEY_STATUS}, 8'h07);
    ob({RQ, CMD_KEY_CHAR}, c);
    ob({NR, CMD_KEY_STATUS}, 8'h06);
    push(1'b1, {NR, CMD_DISK_WRITE});
    pb = {8'($urandom), 32'($urandom)};
    q_pb.push_back(pb);
    push(1'b1, {RQ, CMD_PARAM_FIRST});
    push(1'b0, pb.channel);
    for (int i = 3; i >= 0; i--) begin
      push(1'b1, {NR, CMD_PARAM_NEXT});
      push(1'b0, pb[i*8 +: 8]);
    end
    ob({NR, CMD_DEV_STATUS}, 8'h24);
    drain;
    push(1'b1, {NR, CMD_INT_ENABLE});
    push(1'b0, 8'h03);
    c = 8'($urandom);
    q_ch.push_back(c);
    push(1'b1, {NR, CMD_DISP_CHAR});
    push(1'b0, c);
    drain;
    key   <= c;
    press <= 1'b1;
    @(posedge i_clk);
    press <= 1'b0;
    repeat (2) @(posedge i_clk);
    ob({NR, CMD_DEV_STATUS}, 8'h07);
    push(1'b1, {NR, CMD_INT_RESET});
    push(1'b0, 8'h05);
    ob({NR, CMD_DEV_STATUS}, 8'h02);
    ob({NR, CMD_KEY_CHAR}, c);
    plug <= 1'b0;
    ob({NR, CMD_KEY_STATUS}, 8'h02);
    drain;
    plug <= 1'b1;
    hold <= 1'b1;
    for (int i = 0; i < 9; i++) ob({NR, CMD_DISP_STATUS}, 8'h00);
    i_hb_wr <= 1'b0;
    @(negedge i_clk);
    cmp8({7'h0, o_hb_ready}, 8'h00, 8'hff);
    hold <= 1'b0;
    drain;
    final_report;
  end
endmodule // tb_ich_top
`default_nettype wire
